// [logic/fid_dev.sv]
// Flash device end: ID reads and deep power-down control
`timescale 1ns/1ps
`default_nettype none
module fid_dev (
  input  wire logic clk_sys,   // System clock
  input  wire logic sys_rst,   // Async reset, power cycle
  fid_spi_if.dev    spi,       // Serial link
  input  wire logic busy,      // Self-timed operation running
  output logic      standby,   // Device in standby
  output logic      deep_pd    // Device in deep power-down
);

  typedef struct packed {
    // Synchronised pins and their settled levels
    logic [2:0]         cs_sy;
    logic [2:0]         sck_sy;
    logic [2:0]         si_sy;
    logic               sel_f;
    logic               sck_f;
    // Opcode capture
    fid_pkg::fid_mode_t mode;
    logic [2:0]         bit_cnt;
    logic               got_byte;
    logic [7:0]         sh;
    logic               pd_req;
    logic               rs_req;
    // Reply shifter
    logic [31:0]        osh;
    logic [5:0]         obits;
    logic               so;
    logic               so_oe;
    // Power state and its timer
    fid_pkg::fid_pwr_t  pwr;
    logic [7:0]         tmr;
  } fid_dev_st_t;

  // ==========================================================
  // State and helper signals
  fid_dev_st_t q;
  fid_dev_st_t n;
  logic [7:0]  opc;
  logic        rise;
  logic        fall;
  logic        sel_start;
  logic        sel_end;
  logic        byte_end;
  logic        out_left;
  logic        frame_ok;
  logic        pd_go;
  logic        rs_go;
  logic [31:0] std_word;
  logic [31:0] leg_word;

  // ==========================================================
  // Reply words, first byte in the top bits
  assign std_word = {fid_pkg::MFR_ID,
                     fid_pkg::FAMILY_CODE, fid_pkg::DENSITY_CODE,
                     fid_pkg::SUB_CODE, fid_pkg::VERSION_CODE,
                     fid_pkg::EXT_INFO_LEN};
  assign leg_word = {fid_pkg::MFR_ID, fid_pkg::LEGACY_CODE, 16'h0000};

  // ==========================================================
  // Next state
  // Pins settle through three stages, so the serial clock must keep
  // each level for several system clocks or edges are lost
  always_comb begin
    n = q;
    // Input synchronisers, a level counts once two stages agree
    n.cs_sy  = {q.cs_sy[1:0], ~spi.cs_n};
    n.sck_sy = {q.sck_sy[1:0], spi.sck};
    n.si_sy  = {q.si_sy[1:0], spi.si};
    if (q.cs_sy[1] == q.cs_sy[2]) begin
      n.sel_f = q.cs_sy[2];
    end
    if (q.sck_sy[1] == q.sck_sy[2]) begin
      n.sck_f = q.sck_sy[2];
    end

    // ==========================================================
    // Frame events seen on settled levels
    sel_start = ~q.sel_f & n.sel_f;
    sel_end   = q.sel_f & ~n.sel_f;
    rise      = ~q.sck_f & n.sck_f & n.sel_f;
    fall      = q.sck_f & ~n.sck_f & n.sel_f;
    opc       = {q.sh[6:0], q.si_sy[2]};
    byte_end  = rise & (q.bit_cnt == 3'h7);
    out_left  = (q.obits != 6'h00);
    frame_ok  = q.got_byte & (q.bit_cnt == 3'h0);
    pd_go     = frame_ok & q.pd_req & ~busy & (q.pwr == fid_pkg::PWR_STANDBY);
    rs_go     = frame_ok & q.rs_req & (q.pwr == fid_pkg::PWR_DEEP);

    // ==========================================================
    // Power transitions after a frame
    case (q.pwr)
      fid_pkg::PWR_ENTERING: begin
        n.tmr = q.tmr - 8'h01;
        if (q.tmr == 8'h01) begin
          n.pwr = fid_pkg::PWR_DEEP;
        end
      end
      fid_pkg::PWR_EXITING: begin
        n.tmr = q.tmr - 8'h01;
        if (q.tmr == 8'h01) begin
          n.pwr = fid_pkg::PWR_STANDBY;
        end
      end
      default: begin
        n.tmr = q.tmr;
      end
    endcase

    // New frame: drop whatever the last command left behind
    if (sel_start) begin
      n.mode     = fid_pkg::M_OPCODE;
      n.bit_cnt  = 3'h0;
      n.got_byte = 1'b0;
      n.pd_req   = 1'b0;
      n.rs_req   = 1'b0;
      n.obits    = 6'h00;
    end

    // ==========================================================
    // Sample on the rising serial clock, MSB first
    if (rise) begin
      n.sh      = opc;
      n.bit_cnt = q.bit_cnt + 3'h1;
      if (byte_end) begin
        n.got_byte = 1'b1;
        if (q.mode == fid_pkg::M_OPCODE) begin
          n.mode = fid_pkg::M_IGNORE;
          if (q.pwr == fid_pkg::PWR_STANDBY) begin
            case (opc)
              fid_pkg::OP_JEDEC_ID: begin
                n.mode  = fid_pkg::M_ID_OUT;
                n.osh   = std_word;
                n.obits = fid_pkg::STD_ID_BITS;
              end
              fid_pkg::OP_LEGACY_ID: begin
                n.mode  = fid_pkg::M_ID_OUT;
                // Low half stays zero; only 16 bits go out
                n.osh   = leg_word;
                n.obits = fid_pkg::LEG_ID_BITS;
              end
              fid_pkg::OP_PWR_DOWN: begin
                n.pd_req = 1'b1;
              end
              default: begin
                n.mode = fid_pkg::M_IGNORE;
              end
            endcase
          end else if (q.pwr == fid_pkg::PWR_DEEP && opc == fid_pkg::OP_RESUME) begin
            n.rs_req = 1'b1;
          end
        end
      end
    end

    // ==========================================================
    // Change on the falling serial clock, float once all bytes are out
    if (fall && q.mode == fid_pkg::M_ID_OUT) begin
      if (out_left) begin
        n.so    = q.osh[31];
        n.osh   = {q.osh[30:0], 1'b0};
        n.obits = q.obits - 6'h01;
        n.so_oe = 1'b1;
      end else begin
        // Past the last bit the line is released for good
        n.so_oe = 1'b0;
      end
    end

    // ==========================================================
    // Frame end
    if (sel_end) begin
      n.so_oe = 1'b0;
      n.mode  = fid_pkg::M_IGNORE;
      n.obits = 6'h00;
      // Act only on a whole opcode ending on a byte boundary; busy at
      // release refuses the power-down and the host must reissue it
      if (pd_go) begin
        n.pwr = fid_pkg::PWR_ENTERING;
        n.tmr = fid_pkg::PD_ENTRY_CYC;
      end else if (rs_go) begin
        n.pwr = fid_pkg::PWR_EXITING;
        n.tmr = fid_pkg::PD_EXIT_CYC;
      end
    end
  end

  // ==========================================================
  // State register; all-zero reset is standby
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign spi.so_o  = q.so;
  assign spi.so_oe = q.so_oe;
  assign standby   = (q.pwr == fid_pkg::PWR_STANDBY) & ~q.sel_f & ~busy;
  // Still powered down until the exit time has run out
  assign deep_pd   = (q.pwr == fid_pkg::PWR_DEEP) | (q.pwr == fid_pkg::PWR_EXITING);

endmodule
`default_nettype wire

// [logic/fid_pkg.sv]
// Shared constants and types for the flash identification and power-down slice
// Functional notes
// - Standard ID opcode returns maker, two device bytes, length
// - Length byte is zero, then output floats
// - Chip select release ends standard ID read
// - Device bytes split 3-bit upper, 5-bit lower field
// - Legacy ID returns maker then one device code
// - Chip select release ends legacy ID read
// - Standby while deselected and no self-timed work
// - Power-down opcode plus release enters deep power-down
// - Deep power-down ignores all but resume
// - Partial or misaligned power-down aborts to standby
// - Power-down ignored while busy; host reissues later
// - Power-up starts in standby
// - Resume opcode plus release returns to standby
// - Partial or misaligned resume stays powered down
// - Host identifies at a modest serial clock
// - Host may stop ID read early
package fid_pkg;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_JEDEC_ID  = 8'h9F;
  localparam logic [7:0] OP_LEGACY_ID = 8'h15;
  localparam logic [7:0] OP_PWR_DOWN  = 8'hB9;
  localparam logic [7:0] OP_RESUME    = 8'hAB;

  // ==========================================================
  // Identification values (values arbitrary)
  localparam logic [7:0] MFR_ID       = 8'h5A;
  localparam logic [2:0] FAMILY_CODE  = 3'h3;
  localparam logic [4:0] DENSITY_CODE = 5'h01;
  localparam logic [2:0] SUB_CODE     = 3'h0;
  localparam logic [4:0] VERSION_CODE = 5'h02;
  localparam logic [7:0] LEGACY_CODE  = 8'hA6;
  localparam logic [7:0] EXT_INFO_LEN = 8'h00;
  localparam int         UPPER_LSB    = 5;
  localparam logic [5:0] STD_ID_BITS  = 6'h20;
  localparam logic [5:0] LEG_ID_BITS  = 6'h10;

  // ==========================================================
  // Timing
  localparam int         CLK_PERIOD_NS    = 100;
  localparam int         PD_ENTRY_TIME_NS = 3000;
  localparam int         PD_EXIT_TIME_NS  = 8000;
  localparam logic [7:0] PD_ENTRY_CYC     =
    8'((PD_ENTRY_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : PD_ENTRY_TIME_NS / CLK_PERIOD_NS);
  localparam logic [7:0] PD_EXIT_CYC      =
    8'((PD_EXIT_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : PD_EXIT_TIME_NS / CLK_PERIOD_NS);
  localparam logic [4:0] SCK_HALF_CYC     = 5'h08;
  localparam logic [4:0] CS_GAP_CYC       = 5'h10;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {PWR_STANDBY, PWR_ENTERING, PWR_DEEP, PWR_EXITING} fid_pwr_t;
  typedef enum logic [1:0] {M_OPCODE, M_ID_OUT, M_IGNORE} fid_mode_t;
  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_TAIL, H_GAP} fid_hst_t;

endpackage

// [logic/fid_spi_if.sv]
// Serial link between the flash slice and its host master
`timescale 1ns/1ps
`default_nettype none
interface fid_spi_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so_o;
  logic so_oe;
  logic so;

  // Released output line reads high
  assign so = so_oe ? so_o : 1'b1;

  modport dev (input cs_n, input sck, input si, output so_o, output so_oe);
  modport host (output cs_n, output sck, output si, input so);
endinterface
`default_nettype wire

// [logic/fid_host.sv]
// Host master end: issues one opcode and reads back up to four bytes
`timescale 1ns/1ps
`default_nettype none
module fid_host (
  input  wire logic        clk_sys,    // System clock
  input  wire logic        sys_rst,    // Async reset
  fid_spi_if.host          spi,        // Serial link
  input  wire logic        cmd_valid,  // Command request
  output logic             cmd_ready,  // Ready for a command
  input  wire logic [7:0]  cmd_op,     // Opcode to send
  input  wire logic [2:0]  rx_len,     // Bytes to read, 0 to 4
  output logic [31:0]      rx_data,    // Bytes read, last in low bits
  output logic             done        // Frame finished pulse
);

  typedef struct packed {
    fid_pkg::fid_hst_t st;
    logic [4:0]        div;
    logic              sck;
    logic              cs_act;
    logic              si;
    logic [7:0]        tx;
    logic [31:0]       rx;
    logic [5:0]        bit_idx;
    logic [5:0]        total;
    logic [2:0]        so_sy;
    logic              so_f;
    logic              done;
  } fid_host_st_t;

  fid_host_st_t q;
  fid_host_st_t n;

  // ==========================================================
  // Next state
  always_comb begin
    n       = q;
    n.done  = 1'b0;
    n.so_sy = {q.so_sy[1:0], spi.so};
    if (q.so_sy[1] == q.so_sy[2]) begin
      n.so_f = q.so_sy[2];
    end
    case (q.st)
      fid_pkg::H_IDLE: begin
        // Any command whenever idle; a refused power-down is reissued by the caller
        if (cmd_valid) begin
          n.cs_act  = 1'b1;
          n.tx      = cmd_op;
          n.si      = cmd_op[7];
          n.rx      = 32'h0000_0000;
          n.bit_idx = 6'h00;
          n.total   = 6'h08 + {rx_len, 3'b000};
          n.div     = fid_pkg::SCK_HALF_CYC - 5'h01;
          n.st      = fid_pkg::H_SHIFT;
        end
      end
      fid_pkg::H_SHIFT: begin
        if (q.div != 5'h00) begin
          n.div = q.div - 5'h01;
        end else begin
          n.div = fid_pkg::SCK_HALF_CYC - 5'h01;
          if (!q.sck) begin
            n.sck     = 1'b1;
            n.bit_idx = q.bit_idx + 6'h01;
            if (q.bit_idx >= 6'h08) begin
              // Take the level settled at this edge; the older one is a bit behind
              n.rx = {q.rx[30:0], n.so_f};
            end
          end else begin
            n.sck = 1'b0;
            n.tx  = {q.tx[6:0], 1'b0};
            n.si  = q.tx[6];
            if (q.bit_idx == q.total) begin
              n.st = fid_pkg::H_TAIL;
            end
          end
        end
      end
      fid_pkg::H_TAIL: begin
        if (q.div != 5'h00) begin
          n.div = q.div - 5'h01;
        end else begin
          n.cs_act = 1'b0;
          n.div    = fid_pkg::CS_GAP_CYC - 5'h01;
          n.st     = fid_pkg::H_GAP;
        end
      end
      fid_pkg::H_GAP: begin
        if (q.div != 5'h00) begin
          n.div = q.div - 5'h01;
        end else begin
          n.done = 1'b1;
          n.st   = fid_pkg::H_IDLE;
        end
      end
      default: begin
        n.st = fid_pkg::H_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign spi.cs_n  = ~q.cs_act;
  assign spi.sck   = q.sck;
  assign spi.si    = q.si;
  assign cmd_ready = (q.st == fid_pkg::H_IDLE);
  assign rx_data   = q.rx;
  assign done      = q.done;

endmodule
`default_nettype wire

// [test/fid_monitor.sv]
// Checker on the serial link and power state of the device end
`timescale 1ns/1ps
`default_nettype none
module fid_monitor (
  input wire logic clk_sys,  // System clock
  input wire logic sys_rst,  // Async reset
  input wire logic cs_n,     // Chip select, active low
  input wire logic sck,      // Serial clock
  input wire logic so_o,     // Device data
  input wire logic so_oe,    // Device drives data
  input wire logic busy,     // Self-timed work running
  input wire logic standby,  // Standby state
  input wire logic deep_pd   // Deep power-down state
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Framing and output
  sequence cs_idle_s; cs_n [*8]; endsequence
  sequence cs_rise_s; $rose(cs_n) ##1 cs_n; endsequence
  rel_floats_out_a: assert property (cs_idle_s |-> !so_oe)
    else $error("Output driven while deselected");
  out_on_fall_a: assert property ($changed(so_o) |-> !sck)
    else $error("Output bit changed while clock high");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("Serial clock high while deselected");
  out_starts_a: assert property ($rose(so_oe) |-> !sck && !cs_n)
    else $error("Output enabled outside a selected low phase");
  // ==========================================================
  // Power state
  pd_entry_wait_a: assert property ($rose(deep_pd) |-> cs_n && $past(cs_n, 30))
    else $error("Power-down entered too early");
  pd_not_early_a: assert property (cs_rise_s |-> $stable(deep_pd) [*8])
    else $error("Power state changed right after release");
  exit_wait_a: assert property ($fell(deep_pd) |-> cs_n && $past(cs_n, 70))
    else $error("Power-down left too early");
  deep_not_sb_a: assert property (deep_pd |-> !standby)
    else $error("Standby while powered down");
  busy_not_sb_a: assert property (busy |-> !standby)
    else $error("Standby while busy");
  sel_not_sb_a: assert property (!cs_n [*8] |-> !standby)
    else $error("Standby while selected");
  reset_sb_a: assert property ($fell(sys_rst) |-> !deep_pd && (standby || busy))
    else $error("Reset did not leave standby");
endmodule
`default_nettype wire

// [test/flash_id_and_power_down_cmds_tb.sv]
// Testbench joining host and device ends over the serial link
`timescale 1ns/1ps
`default_nettype none
module flash_id_and_power_down_cmds_tb;
  logic        clk_sys   = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        busy      = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [7:0]  cmd_op    = 8'h00;
  logic [2:0]  rx_len    = 3'h0;
  logic        cmd_ready, done, standby, deep_pd, sb_b, pd_b;
  logic [31:0] rx_data;
  logic [15:0] id_ops [2] = '{16'h9F00, 16'h1500};
  int          fail_count = 0;
  int          n_checks   = 0;
  // ==========================================================
  // Ends and monitor
  fid_spi_if link_a ();
  fid_spi_if link_b ();
  fid_dev u_fid_dev (.clk_sys(clk_sys), .sys_rst(sys_rst), .spi(link_a), .busy(busy),
    .standby(standby), .deep_pd(deep_pd));
  fid_host u_fid_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .spi(link_a), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .rx_len(rx_len), .rx_data(rx_data), .done(done));
  // Second device, driven bit by bit to break framing on purpose
  fid_dev u_fid_dev_b (.clk_sys(clk_sys), .sys_rst(sys_rst), .spi(link_b), .busy(1'b0),
    .standby(sb_b), .deep_pd(pd_b));
  fid_monitor u_fid_monitor (.clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(link_a.cs_n),
    .sck(link_a.sck), .so_o(link_a.so_o), .so_oe(link_a.so_oe), .busy(busy),
    .standby(standby), .deep_pd(deep_pd));
  always #50 clk_sys = ~clk_sys;
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [2:0] len);
    int i;
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_op    = op;
    rx_len    = len;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    chk({31'h0, cmd_ready}, 32'h0);
    for (i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clk_sys);
    chk({31'h0, done}, 32'h1);
    chk({31'h0, cmd_ready}, 32'h1);
  endtask
  task automatic bang(input logic [15:0] v, input int n);
    link_b.cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      link_b.si = v[15-i];
      repeat (8) @(negedge clk_sys);
      link_b.sck = 1'b1;
      repeat (8) @(negedge clk_sys);
      link_b.sck = 1'b0;
    end
  endtask
  task automatic rel(input int w);
    repeat (8) @(negedge clk_sys);
    link_b.cs_n = 1'b1;
    link_b.si   = ~link_b.si;
    repeat (w) @(negedge clk_sys);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    link_b.cs_n = 1'b1;
    link_b.sck  = 1'b0;
    link_b.si   = 1'b0;
    repeat (8) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk({30'h0, standby, deep_pd}, 32'h2);
    cmd(fid_pkg::OP_JEDEC_ID, 3'h4);
    chk(rx_data, {fid_pkg::MFR_ID, fid_pkg::FAMILY_CODE, fid_pkg::DENSITY_CODE,
      fid_pkg::SUB_CODE, fid_pkg::VERSION_CODE, fid_pkg::EXT_INFO_LEN});
    cmd(fid_pkg::OP_JEDEC_ID, 3'h2);
    chk(rx_data, {16'h0, fid_pkg::MFR_ID, fid_pkg::FAMILY_CODE, fid_pkg::DENSITY_CODE});
    cmd(fid_pkg::OP_LEGACY_ID, 3'h3);
    chk(rx_data, {8'h0, fid_pkg::MFR_ID, fid_pkg::LEGACY_CODE, 8'hFF});
    busy = 1'b1;
    cmd(fid_pkg::OP_PWR_DOWN, 3'h0);
    repeat (60) @(negedge clk_sys);
    chk({30'h0, standby, deep_pd}, 32'h0);
    busy = 1'b0;
    cmd(fid_pkg::OP_PWR_DOWN, 3'h1);
    repeat (60) @(negedge clk_sys);
    chk({30'h0, standby, deep_pd}, 32'h1);
    cmd(fid_pkg::OP_JEDEC_ID, 3'h1);
    chk(rx_data, 32'hFF);
    cmd(fid_pkg::OP_RESUME, 3'h1);
    repeat (100) @(negedge clk_sys);
    chk({30'h0, standby, deep_pd}, 32'h2);
    bang(16'hB900, 7);
    rel(60);
    chk({30'h0, sb_b, pd_b}, 32'h2);
    bang(16'hB900, 11);
    rel(60);
    chk({30'h0, sb_b, pd_b}, 32'h2);
    bang(16'hB9FF, 16);
    rel(60);
    chk({30'h0, sb_b, pd_b}, 32'h1);
    bang(16'hAB00, 12);
    rel(100);
    chk({31'h0, pd_b}, 32'h1);
    bang(16'hAB00, 5);
    rel(100);
    chk({31'h0, pd_b}, 32'h1);
    bang(16'hAB00, 8);
    rel(100);
    chk({30'h0, sb_b, pd_b}, 32'h2);
    foreach (id_ops[k]) begin
      bang(id_ops[k], 12);
      chk({31'h0, link_b.so_oe}, 32'h1);
      rel(8);
      chk({31'h0, link_b.so_oe}, 32'h0);
      repeat (20) @(negedge clk_sys);
    end
    stop_test();
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
